//--- fwpc_pkg.sv
package fwpc_pkg;
	// register indices; each byte address is four times its index
	localparam logic [23:0] FWPC_IDX_PROG_BLOCK = 24'h30000a;
	localparam logic [23:0] FWPC_IDX_SPECIAL = 24'h30000b;
	localparam logic [31:0] FWPC_ADDR_PROG_BLOCK = {6'h00, FWPC_IDX_PROG_BLOCK, 2'h0};
	localparam logic [31:0] FWPC_ADDR_SPECIAL = {6'h00, FWPC_IDX_SPECIAL, 2'h0};
	localparam logic [31:0] FWPC_ADDR_CONTROL = 32'h0000_0000;
	localparam logic [31:0] FWPC_ADDR_STATUS = 32'h0000_0004;
	// field positions
	localparam int FWPC_BIT_DATA = 7;
	localparam int FWPC_BIT_BOOT = 6;
	localparam int FWPC_BIT_CONFIG = 5;
	localparam int FWPC_BIT_PROG_MODE = 0;
	localparam int FWPC_BIT_ERASE_ALL = 1;
	// fitted program block counts that the region table covers
	localparam int FWPC_MIN_BLOCKS = 3;
	localparam int FWPC_MAX_BLOCKS = 4;
	// implemented-bit masks and erased values
	localparam logic [7:0] FWPC_MASK_PROG_BLOCK = 8'h0f;
	localparam logic [7:0] FWPC_MASK_SPECIAL = 8'he0;
	localparam logic [7:0] FWPC_ERASED = 8'hff;
	// protected regions
	localparam logic [21:0] FWPC_BOOT_LO = 22'h000000;
	localparam logic [21:0] FWPC_BOOT_HI = 22'h0007ff;
	localparam logic [21:0] FWPC_BLK0_LO = 22'h000800;
	localparam logic [21:0] FWPC_BLK0_HI = 22'h001fff;
	localparam logic [21:0] FWPC_BLK1_LO = 22'h002000;
	localparam logic [21:0] FWPC_BLK1_HI = 22'h003fff;
	localparam logic [21:0] FWPC_BLK2_LO = 22'h004000;
	localparam logic [21:0] FWPC_BLK2_HI = 22'h005fff;
	localparam logic [21:0] FWPC_BLK3_LO = 22'h006000;
	localparam logic [21:0] FWPC_BLK3_HI = 22'h007fff;
	localparam logic [21:0] FWPC_CFG_LO = 22'h300000;
	localparam logic [21:0] FWPC_CFG_HI = 22'h3000ff;
	// sequencer request
	typedef struct packed {
		logic valid;
		logic data_mem;
		logic [21:0] addr;
	} fwpc_req_type;
	typedef enum logic [1:0] {
		FWPC_IDLE = 2'b00,
		FWPC_ACCESS = 2'b01
	} fwpc_state_type;
endpackage

//--- fwpc_region_check.sv
`timescale 1ns/100ps
`default_nettype none
// combinational region decode of one request against protection bits
module fwpc_region_check
	import fwpc_pkg::*;
(
	input wire fwpc_req_type req,
	input wire logic [3:0] block_protect_n,
	input wire logic data_mem_protect_n,
	input wire logic boot_protect_n,
	input wire logic config_protect_n,
	output logic allow
);
	function automatic logic in_range(input logic [21:0] a, input logic [21:0] lo,
		input logic [21:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// allow unless target region has its protect bit cleared
	always_comb begin
		allow = 1'b1;
		if (req.data_mem) begin
			allow = data_mem_protect_n;
		end else if (in_range(req.addr, FWPC_BOOT_LO, FWPC_BOOT_HI)) begin
			allow = boot_protect_n;
		end else if (in_range(req.addr, FWPC_BLK0_LO, FWPC_BLK0_HI)) begin
			allow = block_protect_n[0];
		end else if (in_range(req.addr, FWPC_BLK1_LO, FWPC_BLK1_HI)) begin
			allow = block_protect_n[1];
		end else if (in_range(req.addr, FWPC_BLK2_LO, FWPC_BLK2_HI)) begin
			allow = block_protect_n[2];
		end else if (in_range(req.addr, FWPC_BLK3_LO, FWPC_BLK3_HI)) begin
			allow = block_protect_n[3];
		end else if (in_range(req.addr, FWPC_CFG_LO, FWPC_CFG_HI)) begin
			allow = config_protect_n;
		end
	end
endmodule
`default_nettype wire

//--- fwpc_write_protect.sv
// Overview of operation
// - block protect bits at 30000Ah, bits 3-0
// - data, boot, config bits at 30000Bh bits 7-5
// - block three bit zero blocks 006000-007FFFh
// - block two bit zero blocks 004000-005FFFh
// - block one bit zero blocks 002000-003FFFh
// - data bit zero blocks data memory writes
// - boot bit zero blocks 000000-0007FFh
// - config bit zero blocks 300000-3000FFh
// - config bit writable only in programming mode
// - unimplemented bits always read zero
`timescale 1ns/100ps
`default_nettype none
module fwpc_write_protect
	import fwpc_pkg::*;
#(
	parameter int NUM_BLOCKS = 4
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic prog_mode_pin,
	input wire fwpc_req_type seq_req,
	output logic seq_grant,
	output logic seq_deny
);
	// protection cells, erased state ones
	logic [7:0] prog_block;
	logic [7:0] special;
	logic [7:0] next_prog_block;
	logic [7:0] next_special;
	logic erase_pending;
	logic next_erase_pending;
	// programming-mode strap, synchronised
	logic prog_meta;
	logic prog_sync;
	// bus slave state
	fwpc_state_type state;
	fwpc_state_type next_state;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	// sequencer answer
	logic next_grant;
	logic next_deny;
	logic allow;
	logic [31:0] deny_count;
	logic [31:0] next_deny_count;
	// fitted-block mask and the bits handed to the region decode
	logic [3:0] block_live;
	logic [3:0] block_enable_n;
	logic next_prog_meta;
	logic next_prog_sync;

	// only the three- and four-block layouts have regions defined
	if (NUM_BLOCKS < FWPC_MIN_BLOCKS || NUM_BLOCKS > FWPC_MAX_BLOCKS) begin : g_bad_blocks
		$error("fitted block count out of range");
	end

	// reading view with unimplemented bits forced low
	function automatic logic [31:0] read_value(input logic [31:0] a, input logic [7:0] pb,
		input logic [7:0] sp, input logic pm, input logic [31:0] dc);
		read_value = 32'h0000_0000;
		if (a == FWPC_ADDR_PROG_BLOCK) begin
			read_value = {24'h000000, pb & FWPC_MASK_PROG_BLOCK};
		end else if (a == FWPC_ADDR_SPECIAL) begin
			read_value = {24'h000000, sp & FWPC_MASK_SPECIAL};
		end else if (a == FWPC_ADDR_STATUS) begin
			read_value = dc << 1;
			read_value[FWPC_BIT_PROG_MODE] = pm;
		end
	endfunction

	function automatic logic mapped(input logic [31:0] a);
		mapped = (a == FWPC_ADDR_PROG_BLOCK) || (a == FWPC_ADDR_SPECIAL) ||
			(a == FWPC_ADDR_CONTROL) || (a == FWPC_ADDR_STATUS);
	endfunction

	// true when a program address lies inside protect block idx
	function automatic logic in_block(input logic [21:0] a, input int idx);
		in_block = 1'b0;
		if (idx == 0) begin
			in_block = (a >= FWPC_BLK0_LO) && (a <= FWPC_BLK0_HI);
		end else if (idx == 1) begin
			in_block = (a >= FWPC_BLK1_LO) && (a <= FWPC_BLK1_HI);
		end else if (idx == 2) begin
			in_block = (a >= FWPC_BLK2_LO) && (a <= FWPC_BLK2_HI);
		end else if (idx == 3) begin
			in_block = (a >= FWPC_BLK3_LO) && (a <= FWPC_BLK3_HI);
		end
	endfunction

	// two-flop synchroniser for the programming-mode pin
	always_comb begin
		next_prog_meta = prog_mode_pin;
		next_prog_sync = prog_meta;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prog_meta <= 1'b0;
			prog_sync <= 1'b0;
		end else begin
			prog_meta <= next_prog_meta;
			prog_sync <= next_prog_sync;
		end
	end

	// bits of blocks that are not fitted never protect
	for (genvar g = 0; g < FWPC_MAX_BLOCKS; g++) begin : g_live
		assign block_live[g] = (g < NUM_BLOCKS);
	end
	assign block_enable_n = prog_block[3:0] | ~block_live;

	// region decode
	fwpc_region_check u_check (
		.req(seq_req),
		.block_protect_n(block_enable_n),
		.data_mem_protect_n(special[FWPC_BIT_DATA]),
		.boot_protect_n(special[FWPC_BIT_BOOT]),
		.config_protect_n(special[FWPC_BIT_CONFIG]),
		.allow(allow)
	);

	// apb access and protection cell updates
	always_comb begin
		next_state = state;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_prog_block = prog_block;
		next_special = special;
		next_erase_pending = 1'b0;
		case (state)
			FWPC_IDLE: begin
				if (psel && !penable) begin
					next_state = FWPC_ACCESS;
					next_pready = 1'b1;
					next_pslverr = !mapped(paddr);
					next_prdata = pwrite ? 32'h0000_0000 :
						read_value(paddr, prog_block, special, prog_sync, deny_count);
				end
			end
			FWPC_ACCESS: begin
				next_state = FWPC_IDLE;
				if (pwrite && psel && penable && pready) begin
					if (paddr == FWPC_ADDR_PROG_BLOCK) begin
						// writes only clear bits
						next_prog_block = prog_block & (pwdata[7:0] | ~FWPC_MASK_PROG_BLOCK);
					end else if (paddr == FWPC_ADDR_SPECIAL) begin
						next_special[FWPC_BIT_DATA] = special[FWPC_BIT_DATA] & pwdata[FWPC_BIT_DATA];
						next_special[FWPC_BIT_BOOT] = special[FWPC_BIT_BOOT] & pwdata[FWPC_BIT_BOOT];
						if (prog_sync) begin
							next_special[FWPC_BIT_CONFIG] =
								special[FWPC_BIT_CONFIG] & pwdata[FWPC_BIT_CONFIG];
						end
					end else if (paddr == FWPC_ADDR_CONTROL) begin
						next_erase_pending = pwdata[FWPC_BIT_ERASE_ALL] && prog_sync;
					end
				end
			end
			default: next_state = FWPC_IDLE;
		endcase
		if (erase_pending) begin
			next_prog_block = FWPC_ERASED;
			next_special = FWPC_ERASED;
		end
	end

	// registers; reset restores erased state as no nonvolatile store exists here
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= FWPC_IDLE;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prog_block <= FWPC_ERASED;
			special <= FWPC_ERASED;
			erase_pending <= 1'b0;
		end else begin
			state <= next_state;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			prog_block <= next_prog_block;
			special <= next_special;
			erase_pending <= next_erase_pending;
		end
	end

	// grant or deny each sequencer request one cycle later
	always_comb begin
		next_grant = seq_req.valid && allow;
		next_deny = seq_req.valid && !allow;
		next_deny_count = deny_count;
		if (seq_req.valid && !allow) begin
			next_deny_count = deny_count + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			seq_grant <= 1'b0;
			seq_deny <= 1'b0;
			deny_count <= 32'h0000_0000;
		end else begin
			seq_grant <= next_grant;
			seq_deny <= next_deny;
			deny_count <= next_deny_count;
		end
	end

	// checks
	a_block3_deny: assert property (@(posedge clk_sys) disable iff (reset)
		(seq_req.valid && !seq_req.data_mem && seq_req.addr >= FWPC_BLK3_LO &&
		seq_req.addr <= FWPC_BLK3_HI && block_live[3] && !prog_block[3]) |=>
		(seq_deny && !seq_grant))
		else $error("block three write not denied");
	a_block2_deny: assert property (@(posedge clk_sys) disable iff (reset)
		(seq_req.valid && !seq_req.data_mem && seq_req.addr >= FWPC_BLK2_LO &&
		seq_req.addr <= FWPC_BLK2_HI) |=> (seq_deny == !$past(prog_block[2])))
		else $error("block two decision wrong");
	a_block1_deny: assert property (@(posedge clk_sys) disable iff (reset)
		(seq_req.valid && !seq_req.data_mem && seq_req.addr >= FWPC_BLK1_LO &&
		seq_req.addr <= FWPC_BLK1_HI) |=> (seq_grant == $past(prog_block[1])))
		else $error("block one decision wrong");
	a_data_deny: assert property (@(posedge clk_sys) disable iff (reset)
		(seq_req.valid && seq_req.data_mem) |=> (seq_grant == $past(special[FWPC_BIT_DATA])))
		else $error("data memory decision wrong");
	a_boot_deny: assert property (@(posedge clk_sys) disable iff (reset)
		(seq_req.valid && !seq_req.data_mem && seq_req.addr <= FWPC_BOOT_HI &&
		!special[FWPC_BIT_BOOT]) |=> seq_deny)
		else $error("boot write not denied");
	a_config_deny: assert property (@(posedge clk_sys) disable iff (reset)
		(seq_req.valid && !seq_req.data_mem && seq_req.addr >= FWPC_CFG_LO &&
		seq_req.addr <= FWPC_CFG_HI) |=> (seq_deny == !$past(special[FWPC_BIT_CONFIG])))
		else $error("config decision wrong");
	a_config_locked: assert property (@(posedge clk_sys) disable iff (reset)
		(!prog_sync && !erase_pending) |=> $stable(special[FWPC_BIT_CONFIG]))
		else $error("config bit changed outside programming mode");
	a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (reset)
		(pready && paddr == FWPC_ADDR_PROG_BLOCK) |-> (prdata[31:4] == 28'h0000000))
		else $error("unimplemented block bits not zero");

	a_unimpl_special: assert property (@(posedge clk_sys) disable iff (reset)
		(pready && paddr == FWPC_ADDR_SPECIAL) |->
		(prdata[31:8] == 24'h000000 && prdata[4:0] == 5'h00))
		else $error("unimplemented special bits not zero");
	a_only_clears: assert property (@(posedge clk_sys) disable iff (reset)
		(!$past(erase_pending) && !$past(reset)) |->
		((prog_block & ~$past(prog_block)) == 8'h00 &&
		(special & ~$past(special)) == 8'h00))
		else $error("protect bit set without erase");

	// one decision check per fitted block, grant and deny both
	for (genvar g = 0; g < NUM_BLOCKS; g++) begin : g_blk_chk
		a_block_decide: assert property (@(posedge clk_sys) disable iff (reset)
			(seq_req.valid && !seq_req.data_mem && in_block(seq_req.addr, g)) |=>
			(seq_grant == $past(prog_block[g]) && seq_deny != $past(prog_block[g])))
			else $error("block decision wrong");
	end

	// grant and deny never together
	a_answer_pulse: assert property (@(posedge clk_sys) disable iff (reset)
		!(seq_grant && seq_deny))
		else $error("grant and deny together");

	// no answer without a request the cycle before
	a_answer_only_req: assert property (@(posedge clk_sys) disable iff (reset)
		!seq_req.valid |=> (!seq_grant && !seq_deny))
		else $error("answer without request");

	// full erase brings every cell back to one
	a_erase_restores: assert property (@(posedge clk_sys) disable iff (reset)
		erase_pending |=> (prog_block == FWPC_ERASED && special == FWPC_ERASED))
		else $error("erase did not restore bits");

	// bus answer stands a single cycle
	a_ready_one_cycle: assert property (@(posedge clk_sys) disable iff (reset)
		pready |=> !pready)
		else $error("ready held too long");

	// unprotected boot block is granted
	a_boot_grant: assert property (@(posedge clk_sys) disable iff (reset)
		(seq_req.valid && !seq_req.data_mem && seq_req.addr <= FWPC_BOOT_HI &&
		special[FWPC_BIT_BOOT]) |=> seq_grant)
		else $error("boot write not granted");

	// mode strap passes both flops in order
	a_sync_path: assert property (@(posedge clk_sys) disable iff (reset)
		!$past(reset) |-> (prog_sync == $past(prog_meta)))
		else $error("mode synchroniser skipped a stage");

	// in programming mode a clearing write reaches the config bit
	a_config_clear: assert property (@(posedge clk_sys) disable iff (reset)
		(prog_sync && psel && penable && pready && pwrite && paddr == FWPC_ADDR_SPECIAL &&
		!pwdata[FWPC_BIT_CONFIG] && !erase_pending) |=> !special[FWPC_BIT_CONFIG])
		else $error("config bit not cleared in programming mode");

	// every refusal is counted once
	a_deny_count: assert property (@(posedge clk_sys) disable iff (reset)
		(seq_req.valid && !allow) |=> (deny_count == $past(deny_count) + 32'h0000_0001))
		else $error("refusal not counted");

	// error flag only with the bus answer
	a_slverr_ready: assert property (@(posedge clk_sys) disable iff (reset)
		pslverr |-> pready)
		else $error("error flag without ready");
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import fwpc_pkg::*;
;
	logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, prog_mode_pin;
	logic seq_grant, seq_deny, er;
	logic [31:0] paddr, pwdata, prdata, rd;
	fwpc_req_type seq_req;
	int n_fail = 0;
	int num_checks = 0;

	fwpc_write_protect i_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .prog_mode_pin(prog_mode_pin), .seq_req(seq_req),
		.seq_grant(seq_grant), .seq_deny(seq_deny));

	// free-running core clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic tally_and_finish;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, "read data");
		chk(er, 1'b0, "read error");
	endtask

	// one sequencer request, answer looked at in the following cycle
	task automatic seq(input logic dm, input logic [21:0] a, input logic ok);
		@(posedge clk_sys);
		seq_req <= {1'b1, dm, a};
		@(posedge clk_sys);
		seq_req <= {1'b0, 1'b0, 22'h000000};
		#1;
		chk({seq_grant, seq_deny}, {ok, !ok}, "seq answer");
	endtask

	task automatic t_program_blocks;
		rd_chk(FWPC_ADDR_PROG_BLOCK, 32'h0000_000f);
		apb(1'b1, FWPC_ADDR_PROG_BLOCK, 32'hffff_fff5);
		rd_chk(FWPC_ADDR_PROG_BLOCK, 32'h0000_0005);
		apb(1'b1, FWPC_ADDR_PROG_BLOCK, 32'h0000_00ff);
		rd_chk(FWPC_ADDR_PROG_BLOCK, 32'h0000_0005);
		seq(1'b0, 22'h006000, 1'b0);
		seq(1'b0, 22'h007fff, 1'b0);
		seq(1'b0, 22'h004000, 1'b1);
		seq(1'b0, 22'h005fff, 1'b1);
		seq(1'b0, 22'h002000, 1'b0);
		seq(1'b0, 22'h003fff, 1'b0);
		seq(1'b0, 22'h008000, 1'b1);
	endtask

	task automatic t_special_normal;
		rd_chk(FWPC_ADDR_SPECIAL, 32'h0000_00e0);
		seq(1'b1, 22'h000000, 1'b1);
		seq(1'b0, 22'h0007ff, 1'b1);
		apb(1'b1, FWPC_ADDR_SPECIAL, 32'h0000_0000);
		rd_chk(FWPC_ADDR_SPECIAL, 32'h0000_0020);
		seq(1'b1, 22'h000000, 1'b0);
		seq(1'b0, 22'h0007ff, 1'b0);
		seq(1'b0, 22'h000800, 1'b1);
		seq(1'b0, 22'h300000, 1'b1);
	endtask

	task automatic t_prog_mode_and_erase;
		prog_mode_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		apb(1'b0, FWPC_ADDR_STATUS, 32'h0);
		chk(rd[0], 1'b1, "status mode");
		chk(rd, 32'h0000_000d, "status refusal count");
		apb(1'b1, FWPC_ADDR_SPECIAL, 32'h0000_0000);
		rd_chk(FWPC_ADDR_SPECIAL, 32'h0000_0000);
		seq(1'b0, 22'h3000ff, 1'b0);
		seq(1'b0, 22'h300100, 1'b1);
		apb(1'b1, 32'h0000_0008, 32'h0);
		chk(er, 1'b1, "unmapped error");
		apb(1'b1, FWPC_ADDR_CONTROL, 32'h0000_0002);
		repeat (3) @(posedge clk_sys);
		rd_chk(FWPC_ADDR_PROG_BLOCK, 32'h0000_000f);
		rd_chk(FWPC_ADDR_SPECIAL, 32'h0000_00e0);
		seq(1'b0, 22'h006000, 1'b1);
		seq(1'b1, 22'h000010, 1'b1);
		apb(1'b1, FWPC_ADDR_PROG_BLOCK, 32'h0000_0008);
		rd_chk(FWPC_ADDR_PROG_BLOCK, 32'h0000_0008);
		seq(1'b0, 22'h006000, 1'b1);
		seq(1'b0, 22'h000800, 1'b0);
	endtask

	// stimulus: reset for three cycles, then the scenarios
	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		prog_mode_pin = 1'b0;
		seq_req = {1'b0, 1'b0, 22'h000000};
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		t_program_blocks;
		t_special_normal;
		t_prog_mode_and_erase;
		tally_and_finish;
	end

	// watchdog against a hung handshake
	initial begin
		repeat (3000) @(posedge clk_sys);
		n_fail++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
